/* can_regs_pkg.sv */
// Shared constants for the CAN mode, FIFO and status register set
package can_regs_pkg;
    // Register word addresses on the plain CPU port
    localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
    localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
    localparam logic [3:0] ADDR_VECTOR = 4'h2;
    localparam logic [3:0] ADDR_FIFO_CTRL = 4'h3;
    localparam logic [3:0] ADDR_FIFO_PTR = 4'h4;
    localparam logic [3:0] ADDR_INT_FLAGS = 4'h5;
    localparam logic [3:0] ADDR_INT_EN = 4'h6;
    localparam logic [3:0] ADDR_ERR_CNT = 4'h7;
    localparam logic [3:0] ADDR_EVT_STATUS = 4'h8;
    localparam logic [3:0] ADDR_EVT_MASK = 4'h9;

    // Operating mode codes, shared by request and current fields
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_DISABLE = 3'h1;
    localparam logic [2:0] MODE_LOOPBACK = 3'h2;
    localparam logic [2:0] MODE_LISTEN_ONLY = 3'h3;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    localparam logic [2:0] MODE_RSVD_A = 3'h5;
    localparam logic [2:0] MODE_RSVD_B = 3'h6;
    localparam logic [2:0] MODE_LISTEN_ALL = 3'h7;

    // Control register one field positions
    localparam int STOP_IDLE_BIT = 13;
    localparam int ABORT_BIT = 12;
    localparam int REQ_LSB = 8;
    localparam int CUR_LSB = 5;
    localparam int CAPTURE_BIT = 3;
    localparam int WINDOW_BIT = 0;

    // FIFO control and pointer fields
    localparam int DMA_LSB = 13;
    localparam int FSA_LSB = 0;
    localparam int WPTR_LSB = 8;
    localparam int RPTR_LSB = 0;
    localparam logic [5:0] LAST_BUFFER = 6'h1f;

    // Interrupt flag register layout: state bits high, flags low
    localparam int STATE_LSB = 8;
    localparam logic [7:0] FLAG_MASK = 8'hef;
    localparam int FLAG_TB = 0;
    localparam int FLAG_RB = 1;
    localparam int FLAG_OVF = 2;
    localparam int FLAG_FIFO = 3;
    localparam int FLAG_ERR = 5;
    localparam int FLAG_WAK = 6;
    localparam int FLAG_IVR = 7;

    // Interrupt source codes
    localparam logic [6:0] CODE_FIFO = 7'h44;
    localparam logic [6:0] CODE_OVF = 7'h43;
    localparam logic [6:0] CODE_WAK = 7'h42;
    localparam logic [6:0] CODE_ERR = 7'h41;
    localparam logic [6:0] CODE_NONE = 7'h40;

    // Error confinement thresholds
    localparam logic [7:0] WARN_LEVEL = 8'h60;
    localparam logic [7:0] PASSIVE_LEVEL = 8'h80;

    // Bus idle length in recessive bits
    localparam logic [3:0] IDLE_BITS = 4'hb;

    // Block event status bits
    localparam int EVT_MODE = 0;
    localparam int EVT_ABORT = 1;
endpackage

/* can_link_if.sv */
// Shared CAN bus wire between the controller and another node
`timescale 1ns/1ns
interface can_link_if;
    logic dev_tx;
    logic dev_oe;
    logic far_tx;
    logic far_oe;
    logic bus_level;

    // Wired-AND: a driven low is dominant, undriven reads recessive
    assign bus_level = ~((dev_oe & ~dev_tx) | (far_oe & ~far_tx));

    modport device (output dev_tx, output dev_oe, input bus_level);
    modport far (output far_tx, output far_oe, input bus_level);
endinterface

/* can_far_node.sv */
// Other CAN node end: drives bit levels onto the shared bus
`timescale 1ns/1ns
module can_far_node
    import can_regs_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // User side
    input wire logic drive_in,
    input wire logic tx_bit_in,
    output logic rx_bit_out,
    // Bus side
    can_link_if.far link
);
    logic tx_q;
    logic oe_q;
    logic rx_meta_q;
    logic rx_q;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tx_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (ce_in) begin
            tx_q <= tx_bit_in;
            oe_q <= drive_in;
        end
    end

    // Bus level is asynchronous to this node
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_meta_q <= 1'b1;
            rx_q <= 1'b1;
        end else if (ce_in) begin
            rx_meta_q <= link.bus_level;
            rx_q <= rx_meta_q;
        end
    end

    assign link.far_tx = tx_q;
    assign link.far_oe = oe_q;
    assign rx_bit_out = rx_q;
endmodule

/* can_mode_fifo_status_regs.sv */
// CAN controller mode, FIFO, interrupt and error status registers
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module can_mode_fifo_status_regs
    import can_regs_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // CPU register port
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [15:0] rdata_out,
    output logic irq_out,
    // Protocol engine side
    input wire logic bit_tick_in,
    input wire logic tx_bit_in,
    input wire logic tx_busy_in,
    output logic rx_bit_out,
    output logic [2:0] mode_out,
    output logic abort_all_out,
    input wire logic all_aborted_in,
    input wire logic [7:0] flag_set_in,
    input wire logic [6:0] buffer_code_in,
    input wire logic [4:0] compare_count_in,
    input wire logic [7:0] tec_in,
    input wire logic [7:0] rec_in,
    input wire logic bus_off_in,
    input wire logic rx_stored_in,
    input wire logic rx_consumed_in,
    output logic [2:0] dma_buffer_count_out,
    output logic [4:0] fifo_start_out,
    // Bus side
    can_link_if.device link
);
    logic stop_idle_q, abort_q, capture_q, window_q, rx_meta_q, rx_pin_q;
    logic config_mode, on_bus, rx_int, bus_idle, mode_switch, wr_ctrl_one;
    logic [2:0] req_q, cur_q, dma_q, req_wr;
    logic [3:0] idle_q;
    logic [4:0] fsa_q, data_bit_compare_count_q;
    logic [5:0] wptr_q, rptr_q, state_bits;
    logic [6:0] code_d, code_q;
    logic [7:0] flags_q, enables_q, tec_q, rec_q;
    logic [1:0] evt_q, evt_mask_q;
    logic [15:0] rdata_q, ctrl_one;
    assign config_mode = (cur_q == MODE_CONFIG);
    assign on_bus = (cur_q == MODE_NORMAL) || (cur_q == MODE_LISTEN_ALL);
    assign wr_ctrl_one = ce_in && write_in && (addr_in == ADDR_CTRL_ONE);
    assign req_wr = wdata_in[REQ_LSB +: 3];
    // Pin input passes two flops before use
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_meta_q <= 1'b1;
            rx_pin_q <= 1'b1;
        end else if (ce_in) begin
            rx_meta_q <= link.bus_level;
            rx_pin_q <= rx_meta_q;
        end
    end
    assign rx_int = (cur_q == MODE_LOOPBACK) ? tx_bit_in : rx_pin_q;
    assign rx_bit_out = rx_int;
    // Only active modes drive; loopback and listen modes leave the pin free
    assign link.dev_oe = on_bus && (cur_q != MODE_LISTEN_ALL);
    assign link.dev_tx = tx_bit_in;
    // Recessive bit counter for bus idle detection
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            idle_q <= 4'h0;
        end else if (ce_in && bit_tick_in) begin
            if (!rx_int) begin
                idle_q <= 4'h0;
            end else if (idle_q != IDLE_BITS) begin
                idle_q <= idle_q + 4'h1;
            end
        end
    end
    assign bus_idle = (idle_q == IDLE_BITS);
    // Offline modes are not on the wire, so they may switch at once
    assign mode_switch = (req_q != cur_q) && (bus_idle || !on_bus)
        && !((req_q == MODE_CONFIG) && tx_busy_in);
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            req_q <= MODE_CONFIG;
            cur_q <= MODE_CONFIG;
        end else if (ce_in) begin
            if (wr_ctrl_one && (req_wr != MODE_RSVD_A) && (req_wr != MODE_RSVD_B)) begin
                req_q <= req_wr;
            end
            if (mode_switch) begin
                cur_q <= req_q;
            end
        end
    end
    // Configuration bits of control one, locked outside configuration mode
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            stop_idle_q <= 1'b0;
            capture_q <= 1'b0;
            window_q <= 1'b0;
        end else if (wr_ctrl_one && config_mode) begin
            stop_idle_q <= wdata_in[STOP_IDLE_BIT];
            capture_q <= wdata_in[CAPTURE_BIT];
            window_q <= wdata_in[WINDOW_BIT];
        end
    end
    // Abort request; a new write wins over completion
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            abort_q <= 1'b0;
        end else if (ce_in) begin
            if (wr_ctrl_one && wdata_in[ABORT_BIT]) begin
                abort_q <= 1'b1;
            end else if (all_aborted_in) begin
                abort_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            dma_q <= 3'h0;
            fsa_q <= 5'h00;
        end else if (ce_in && write_in && (addr_in == ADDR_FIFO_CTRL) && config_mode) begin
            dma_q <= wdata_in[DMA_LSB +: 3];
            fsa_q <= wdata_in[FSA_LSB +: 5];
        end
    end
    // Pointers restart at the FIFO start whenever it is reprogrammed
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wptr_q <= 6'h00;
            rptr_q <= 6'h00;
        end else if (ce_in) begin
            if (write_in && (addr_in == ADDR_FIFO_CTRL) && config_mode) begin
                wptr_q <= {1'b0, wdata_in[FSA_LSB +: 5]};
                rptr_q <= {1'b0, wdata_in[FSA_LSB +: 5]};
            end else begin
                if (rx_stored_in) begin
                    wptr_q <= (wptr_q == LAST_BUFFER) ? {1'b0, fsa_q} : wptr_q + 6'h01;
                end
                if (rx_consumed_in) begin
                    rptr_q <= (rptr_q == LAST_BUFFER) ? {1'b0, fsa_q} : rptr_q + 6'h01;
                end
            end
        end
    end
    // Flags: writing 0 clears, a hardware set in the same cycle wins
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            flags_q <= 8'h00;
        end else if (ce_in) begin
            if (write_in && (addr_in == ADDR_INT_FLAGS)) begin
                flags_q <= ((flags_q & wdata_in[7:0]) | flag_set_in) & FLAG_MASK;
            end else begin
                flags_q <= (flags_q | flag_set_in) & FLAG_MASK;
            end
        end
    end
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            enables_q <= 8'h00;
            evt_mask_q <= 2'h0;
        end else if (ce_in && write_in) begin
            if ((addr_in == ADDR_INT_EN) && config_mode) begin
                enables_q <= wdata_in[7:0] & FLAG_MASK;
            end
            if (addr_in == ADDR_EVT_MASK) begin
                evt_mask_q <= wdata_in[1:0];
            end
        end
    end
    // Error counters read zero while in configuration; the compare count does not
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tec_q <= 8'h00;
            rec_q <= 8'h00;
            data_bit_compare_count_q <= 5'h00;
        end else if (ce_in) begin
            tec_q <= config_mode ? 8'h00 : tec_in;
            rec_q <= config_mode ? 8'h00 : rec_in;
            data_bit_compare_count_q <= compare_count_in;
        end
    end
    assign state_bits[5] = bus_off_in;
    assign state_bits[4] = (tec_q >= PASSIVE_LEVEL);
    assign state_bits[3] = (rec_q >= PASSIVE_LEVEL);
    assign state_bits[2] = (tec_q >= WARN_LEVEL);
    assign state_bits[1] = (rec_q >= WARN_LEVEL);
    assign state_bits[0] = state_bits[2] | state_bits[1];
    // Highest pending enabled source wins
    always_comb begin
        if (flags_q[FLAG_FIFO] && enables_q[FLAG_FIFO]) begin
            code_d = CODE_FIFO;
        end else if (flags_q[FLAG_OVF] && enables_q[FLAG_OVF]) begin
            code_d = CODE_OVF;
        end else if (flags_q[FLAG_WAK] && enables_q[FLAG_WAK]) begin
            code_d = CODE_WAK;
        end else if (flags_q[FLAG_ERR] && enables_q[FLAG_ERR]) begin
            code_d = CODE_ERR;
        end else if ((flags_q[FLAG_RB] && enables_q[FLAG_RB]) || (flags_q[FLAG_TB] && enables_q[FLAG_TB])) begin
            code_d = buffer_code_in;
        end else begin
            code_d = CODE_NONE;
        end
    end
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            code_q <= CODE_NONE;
        end else if (ce_in) begin
            code_q <= code_d;
        end
    end
    // Block events; a read clears, a new event in that cycle survives
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            evt_q <= 2'h0;
        end else if (ce_in) begin
            if (read_in && (addr_in == ADDR_EVT_STATUS)) begin
                evt_q <= {abort_q && all_aborted_in, mode_switch};
            end else begin
                evt_q <= evt_q | {abort_q && all_aborted_in, mode_switch};
            end
        end
    end
    assign ctrl_one = {2'b00, stop_idle_q, abort_q, 1'b0, req_q, cur_q, 1'b0,
        capture_q, 2'b00, window_q};
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_q <= 16'h0000;
        end else if (ce_in) begin
            rdata_q <= 16'h0000;
            if (read_in) begin
                case (addr_in)
                    ADDR_CTRL_ONE: rdata_q <= ctrl_one;
                    ADDR_CTRL_TWO: rdata_q <= {11'h000, data_bit_compare_count_q};
                    ADDR_VECTOR: rdata_q <= {9'h000, code_q};
                    ADDR_FIFO_CTRL: rdata_q <= {dma_q, 8'h00, fsa_q};
                    ADDR_FIFO_PTR: rdata_q <= {2'b00, wptr_q, 2'b00, rptr_q};
                    ADDR_INT_FLAGS: rdata_q <= {2'b00, state_bits, flags_q};
                    ADDR_INT_EN: rdata_q <= {8'h00, enables_q};
                    ADDR_ERR_CNT: rdata_q <= {tec_q, rec_q};
                    ADDR_EVT_STATUS: rdata_q <= {14'h0000, evt_q};
                    ADDR_EVT_MASK: rdata_q <= {14'h0000, evt_mask_q};
                    default: rdata_q <= 16'h0000;
                endcase
            end
        end
    end
    assign rdata_out = rdata_q;
    assign irq_out = (|(flags_q & enables_q)) || (|(evt_q & evt_mask_q));
    assign mode_out = cur_q;
    assign abort_all_out = abort_q;
    assign dma_buffer_count_out = dma_q;
    assign fifo_start_out = fsa_q;
endmodule

/* can_regs_assertions.sv */
// Link and mode checks for the CAN register block
`timescale 1ns/1ns
module can_regs_assertions
    import can_regs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Watched signals
    input wire logic dev_oe,
    input wire logic [2:0] mode_out,
    input wire logic abort_all_out,
    input wire logic all_aborted_in,
    input wire logic write_in,
    input wire logic tx_busy_in,
    input wire logic irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    sequence abort_waiting;
        abort_all_out && !all_aborted_in;
    endsequence
    sequence abort_done;
        abort_all_out && all_aborted_in && !write_in;
    endsequence
    a_pin_normal_only: assert property (dev_oe |-> mode_out == MODE_NORMAL)
        else $error("pin driven outside normal mode");
    a_loop_released: assert property (mode_out == MODE_LOOPBACK |-> !dev_oe)
        else $error("pin driven in loopback");
    a_mode_legal: assert property (mode_out != MODE_RSVD_A && mode_out != MODE_RSVD_B)
        else $error("reserved mode entered");
    a_reset_config: assert property ($fell(reset_in) |-> (mode_out == MODE_CONFIG) [*2])
        else $error("mode not config after reset");
    a_reset_quiet: assert property ($fell(reset_in) |-> !abort_all_out && !irq_out && !dev_oe)
        else $error("outputs active after reset");
    a_busy_no_config: assert property (mode_out != MODE_CONFIG && tx_busy_in |=> mode_out != MODE_CONFIG)
        else $error("config entered during transmission");
    a_abort_holds: assert property (abort_waiting |=> abort_all_out)
        else $error("abort dropped early");
    a_abort_clears: assert property (abort_done |=> !abort_all_out)
        else $error("abort not cleared");
endmodule

/* can_mode_fifo_status_regs_tb.sv */
// Self-checking bench for the CAN mode, FIFO and status registers
`timescale 1ns/1ns
module can_mode_fifo_status_regs_tb
    import can_regs_pkg::*;
;
    logic clock_in = 0, reset_in = 1, write_in = 0, read_in = 0, ce_in = 1;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic bit_tick_in = 0, tx_bit_in = 1, tx_busy_in = 0, all_aborted_in = 0;
    logic rx_stored_in = 0, rx_consumed_in = 0, bus_off_in = 0;
    logic far_drive = 0, far_tx = 1;
    logic [7:0] flag_set_in = 8'h00, tec_in = 8'h61, rec_in = 8'h10;
    logic [6:0] buffer_code_in = 7'h05;
    logic [4:0] compare_count_in = 5'h11, fifo_start_out;
    logic [15:0] rdata_out;
    logic irq_out, rx_bit_out, abort_all_out, far_rx;
    logic [2:0] mode_out, dma_buffer_count_out;
    int errors = 0, check_count = 0;
    int fb [5] = '{FLAG_FIFO, FLAG_OVF, FLAG_WAK, FLAG_ERR, FLAG_RB};
    logic [6:0] fc [5] = '{CODE_FIFO, CODE_OVF, CODE_WAK, CODE_ERR, 7'h05};
    can_link_if link();
    can_mode_fifo_status_regs can_mode_fifo_status_regs_inst (.clock_in(clock_in), .reset_in(reset_in),
        .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .bit_tick_in(bit_tick_in), .tx_bit_in(tx_bit_in),
        .tx_busy_in(tx_busy_in), .rx_bit_out(rx_bit_out), .mode_out(mode_out), .abort_all_out(abort_all_out),
        .all_aborted_in(all_aborted_in), .flag_set_in(flag_set_in), .buffer_code_in(buffer_code_in),
        .compare_count_in(compare_count_in), .tec_in(tec_in), .rec_in(rec_in), .bus_off_in(bus_off_in),
        .rx_stored_in(rx_stored_in), .rx_consumed_in(rx_consumed_in),
        .dma_buffer_count_out(dma_buffer_count_out), .fifo_start_out(fifo_start_out), .link(link));
    can_far_node can_far_node_inst (.clock_in(clock_in), .reset_in(reset_in), .ce_in(ce_in),
        .drive_in(far_drive), .tx_bit_in(far_tx), .rx_bit_out(far_rx), .link(link));
    can_regs_assertions can_regs_assertions_inst (.clock_in(clock_in), .reset_in(reset_in),
        .dev_oe(link.dev_oe), .mode_out(mode_out), .abort_all_out(abort_all_out),
        .all_aborted_in(all_aborted_in), .write_in(write_in), .tx_busy_in(tx_busy_in), .irq_out(irq_out));
    always #50 clock_in = ~clock_in;
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m, input string name);
        @(posedge clock_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1;
        check(name, exp, rdata_out & m);
    endtask
    task automatic expect_mode(input logic [2:0] m);
        for (int i = 0; i < 8 && mode_out !== m; i++) cyc(1);
        check("mode", m, mode_out);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (3) @(posedge clock_in);
            bit_tick_in <= 1'b1;
            @(posedge clock_in);
            bit_tick_in <= 1'b0;
        end
        cyc(3);
    endtask
    task automatic t_reset();
        check("mode", MODE_CONFIG, mode_out);
        check("oe", 1'b0, link.dev_oe);
        check("irq", 1'b0, irq_out);
        rd(ADDR_CTRL_ONE, 16'h0480, 16'h17e0, "ctrl one");
        rd(ADDR_ERR_CNT, 16'h0000, 16'hffff, "counters");
        rd(ADDR_VECTOR, CODE_NONE, 16'h007f, "code");
        rd(ADDR_FIFO_CTRL, 16'h0000, 16'hffff, "fifo ctrl");
        rd(ADDR_FIFO_PTR, 16'h0000, 16'hffff, "pointers");
        rd(4'hf, 16'h0000, 16'hffff, "unmapped");
    endtask
    task automatic t_fifo();
        // Clock enable low must block a write to the FIFO control register
        @(posedge clock_in);
        ce_in <= 1'b0;
        wr(ADDR_FIFO_CTRL, 16'h0001);
        ce_in <= 1'b1;
        rd(ADDR_FIFO_CTRL, 16'h0000, 16'hffff, "frozen fifo");
        wr(ADDR_FIFO_CTRL, 16'ha01e);
        cyc(2);
        check("dma count", 3'h5, dma_buffer_count_out);
        check("fifo start", 5'h1e, fifo_start_out);
        rd(ADDR_FIFO_PTR, 16'h1e1e, 16'h3f3f, "pointers");
        repeat (2) begin
            @(posedge clock_in);
            rx_stored_in <= 1'b1;
            @(posedge clock_in);
            rx_stored_in <= 1'b0;
        end
        @(posedge clock_in);
        rx_consumed_in <= 1'b1;
        @(posedge clock_in);
        rx_consumed_in <= 1'b0;
        rd(ADDR_FIFO_PTR, 16'h1e1f, 16'h3f3f, "wrapped pointers");
    endtask
    task automatic t_flags();
        @(posedge clock_in);
        flag_set_in <= 8'h04;
        @(posedge clock_in);
        flag_set_in <= 8'h00;
        cyc(3);
        check("masked irq", 1'b0, irq_out);
        rd(ADDR_INT_FLAGS, 16'h0004, 16'h00ff, "flags");
        rd(ADDR_VECTOR, CODE_NONE, 16'h007f, "masked code");
        wr(ADDR_INT_FLAGS, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_INT_EN, 16'h0001 << fb[i]);
            @(posedge clock_in);
            flag_set_in <= 8'h01 << fb[i];
            @(posedge clock_in);
            flag_set_in <= 8'h00;
            cyc(3);
            check("irq", 1'b1, irq_out);
            rd(ADDR_VECTOR, {9'h000, fc[i]}, 16'h007f, "code");
            wr(ADDR_INT_FLAGS, 16'h00ff);
            rd(ADDR_INT_FLAGS, 16'h0001 << fb[i], 16'h00ff, "kept flag");
            wr(ADDR_INT_FLAGS, 16'h0000);
            cyc(3);
            check("irq cleared", 1'b0, irq_out);
        end
        // Several sources at once: highest first, next after its clear
        wr(ADDR_INT_EN, {8'h00, FLAG_MASK});
        @(posedge clock_in);
        flag_set_in <= (8'h01 << FLAG_ERR) | (8'h01 << FLAG_OVF) | (8'h01 << FLAG_RB);
        @(posedge clock_in);
        flag_set_in <= 8'h00;
        cyc(3);
        rd(ADDR_VECTOR, {9'h000, CODE_OVF}, 16'h007f, "top code");
        wr(ADDR_INT_FLAGS, ~(16'h0001 << FLAG_OVF));
        rd(ADDR_VECTOR, {9'h000, CODE_ERR}, 16'h007f, "next code");
        wr(ADDR_INT_FLAGS, 16'h0000);
        cyc(3);
        check("irq cleared", 1'b0, irq_out);
    endtask
    task automatic t_abort();
        wr(ADDR_CTRL_ONE, 16'h3409);
        cyc(6);
        check("abort", 1'b1, abort_all_out);
        rd(ADDR_CTRL_ONE, 16'h3009, 16'h3009, "abort bit");
        @(posedge clock_in);
        all_aborted_in <= 1'b1;
        @(posedge clock_in);
        all_aborted_in <= 1'b0;
        rd(ADDR_CTRL_ONE, 16'h2009, 16'h3009, "abort bit");
        wr(ADDR_EVT_MASK, 16'h0001 << EVT_ABORT);
        cyc(1);
        check("event irq", 1'b1, irq_out);
        rd(ADDR_EVT_MASK, 16'h0001 << EVT_ABORT, 16'hffff, "event mask");
        rd(ADDR_EVT_STATUS, 16'h0001 << EVT_ABORT, 16'hffff, "event status");
        rd(ADDR_EVT_STATUS, 16'h0000, 16'hffff, "event cleared");
        check("event irq", 1'b0, irq_out);
    endtask
    task automatic t_normal();
        wr(ADDR_CTRL_ONE, 16'h0000);
        expect_mode(MODE_NORMAL);
        check("oe", 1'b1, link.dev_oe);
        rd(ADDR_ERR_CNT, 16'h6110, 16'hffff, "counters");
        rd(ADDR_CTRL_TWO, 16'h0011, 16'h001f, "compare count");
        rd(ADDR_INT_FLAGS, 16'h0500, 16'h3f00, "error state");
        rd(ADDR_EVT_STATUS, 16'h0001 << EVT_MODE, 16'hffff, "mode event");
        @(posedge clock_in);
        tx_bit_in <= 1'b0;
        cyc(4);
        check("far rx", 1'b0, far_rx);
        check("pin rx", 1'b0, rx_bit_out);
        @(posedge clock_in);
        tx_bit_in <= 1'b1;
    endtask
    // Dominant bus first, so a counter that ignores the line is caught
    task automatic t_idle();
        @(posedge clock_in);
        far_drive <= 1'b1;
        far_tx <= 1'b0;
        wr(ADDR_CTRL_ONE, 16'h0300);
        ticks(12);
        check("busy bus mode", MODE_NORMAL, mode_out);
        @(posedge clock_in);
        far_drive <= 1'b0;
        cyc(4);
        ticks(10);
        check("short idle mode", MODE_NORMAL, mode_out);
        ticks(1);
        expect_mode(MODE_LISTEN_ONLY);
        check("listen oe", 1'b0, link.dev_oe);
    endtask
    task automatic t_loop();
        wr(ADDR_CTRL_ONE, 16'h0200);
        expect_mode(MODE_LOOPBACK);
        @(posedge clock_in);
        tx_bit_in <= 1'b0;
        cyc(4);
        check("loop rx", 1'b0, rx_bit_out);
        check("far rx", 1'b1, far_rx);
        @(posedge clock_in);
        tx_bit_in <= 1'b1;
        far_drive <= 1'b1;
        cyc(4);
        check("loop rx", 1'b1, rx_bit_out);
        check("far rx", 1'b0, far_rx);
        @(posedge clock_in);
        far_drive <= 1'b0;
    endtask
    task automatic t_locked();
        wr(ADDR_CTRL_ONE, 16'h0500);
        wr(ADDR_CTRL_ONE, 16'h0600);
        cyc(6);
        check("reserved mode", MODE_LOOPBACK, mode_out);
        rd(ADDR_CTRL_ONE, 16'h0240, 16'h07e0, "mode fields");
        wr(ADDR_CTRL_ONE, 16'h2209);
        rd(ADDR_CTRL_ONE, 16'h0200, 16'h3709, "locked ctrl");
        wr(ADDR_FIFO_CTRL, 16'h0000);
        rd(ADDR_FIFO_CTRL, 16'ha01e, 16'hffff, "locked fifo");
        wr(ADDR_INT_EN, 16'h0000);
        rd(ADDR_INT_EN, {8'h00, FLAG_MASK}, 16'h00ff, "locked enables");
        @(posedge clock_in);
        tx_busy_in <= 1'b1;
        wr(ADDR_CTRL_ONE, 16'h0400);
        cyc(6);
        check("busy mode", MODE_LOOPBACK, mode_out);
        @(posedge clock_in);
        tx_busy_in <= 1'b0;
        expect_mode(MODE_CONFIG);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        cyc(1);
        t_reset();
        t_fifo();
        t_flags();
        t_abort();
        t_normal();
        t_idle();
        t_loop();
        t_locked();
        @(posedge clock_in);
        reset_in <= 1'b1;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        cyc(1);
        t_reset();
        results();
    end
    // Whole run needs about 400 cycles
    initial begin
        cyc(20000);
        errors++;
        results();
    end
endmodule
